// ===== bic_pkg.sv
// Purpose: Shared constants for the board interrupt controller.
// Assumes: APB slave with 32-bit data, 100 MHz ref_clk.
// Notes: Sixty-four interrupt sources spread over register pairs.
package bic_pkg;
  localparam int unsigned BIC_NSRC = 64;
  localparam int unsigned BIC_NEXT = 12;
  localparam logic [11:0] BIC_ADDR_STATUS = 12'h000;
  localparam logic [11:0] BIC_ADDR_FWREV = 12'h004;
  localparam logic [11:0] BIC_ADDR_IDENT = 12'h008;
  localparam logic [11:0] BIC_ADDR_EN1 = 12'h010;
  localparam logic [11:0] BIC_ADDR_EN2 = 12'h014;
  localparam logic [11:0] BIC_ADDR_REQ1 = 12'h020;
  localparam logic [11:0] BIC_ADDR_REQ2 = 12'h024;
  localparam logic [11:0] BIC_ADDR_CLR1 = 12'h030;
  localparam logic [11:0] BIC_ADDR_CLR2 = 12'h034;
  localparam logic [11:0] BIC_ADDR_ARM1 = 12'h040;
  localparam logic [11:0] BIC_ADDR_ARM2 = 12'h044;
  localparam logic [11:0] BIC_ADDR_LVL1 = 12'h050;
  localparam logic [11:0] BIC_ADDR_LVL2 = 12'h054;
  localparam logic [11:0] BIC_ADDR_POL1 = 12'h060;
  localparam logic [11:0] BIC_ADDR_POL2 = 12'h064;
  localparam logic [11:0] BIC_ADDR_RT1 = 12'h070;
  localparam logic [11:0] BIC_ADDR_RT2 = 12'h074;
  localparam logic [11:0] BIC_ADDR_RT3 = 12'h078;
  localparam logic [11:0] BIC_ADDR_ISTAT = 12'h100;
  localparam logic [11:0] BIC_ADDR_IEN = 12'h104;
  localparam logic [11:0] BIC_ADDR_ICLR = 12'h108;
  localparam int unsigned BIC_IDENT_BIT = 7;
  localparam int unsigned BIC_STAT_IRQ_BIT = 0;
  localparam int unsigned BIC_STAT_IDENT_BIT = 1;
  localparam logic [15:0] BIC_FW_REV = 16'h0100;  // Arbitrary revision value.
  localparam logic [15:0] BIC_FW_OPTIONS = 16'h0000;  // Arbitrary options value.
  localparam int unsigned BIC_CLK_HZ = 100_000_000;
  localparam int unsigned BIC_BLINK_MS = 500;
  localparam int unsigned BIC_BLINK_CYC = BIC_CLK_HZ / 1000 * BIC_BLINK_MS;
  localparam int unsigned BIC_NEV = 2;
  localparam int unsigned BIC_EV_PEND = 0;
  localparam int unsigned BIC_EV_EXT = 1;
  typedef enum logic [1:0] {
    BIC_LED_OFF = 2'b00,
    BIC_LED_GREEN = 2'b01,
    BIC_LED_RED = 2'b10
  } bic_led_t;
endpackage

// ===== bic_source.sv
// Purpose: One interrupt source detector with sticky pending flag.
// Assumes: src_raw is already synchronised to ref_clk.
// Notes: Set wins over clear in the same cycle.
`timescale 1ns/100ps
`default_nettype none
module bic_source (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Source and controls.
  input wire logic src_raw,
  input wire logic sw_req,
  input wire logic clr,
  input wire logic arm,
  input wire logic level_mode,
  input wire logic pol_high,
  // Result.
  output logic pending
);
  logic prev_act;
  logic act;
  logic edge_hit;
  logic hit;

  assign act = pol_high ? src_raw : ~src_raw;
  assign edge_hit = act & ~prev_act & arm;
  assign hit = (level_mode ? act : edge_hit) | sw_req;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // A low pin under the default low polarity is active, so no false edge follows reset.
      prev_act <= 1'b1;
    end else begin
      prev_act <= act;
    end
  end

  // Pending holds until cleared; a new hit in the clear cycle survives.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= 1'b0;
    end else if (hit) begin
      pending <= 1'b1;
    end else if (clr) begin
      pending <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== bic_top.sv
// Purpose: Board interrupt controller with APB registers, routing and identify blink.
// Assumes: APB master per the usual protocol; irq_src inputs are asynchronous pins.
// Notes: Zero wait state slave; pslverr flags unmapped addresses.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module bic_top
  import bic_pkg::*;
#(
  parameter int unsigned BLINK_CYC = BIC_BLINK_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt sources and outputs.
  input wire logic [63:0] irq_src,
  output logic [63:0] irq_out,
  output logic [11:0] ext_irq,
  output logic host_irq,
  // Status LEDs.
  input wire logic board_ok,
  output logic [1:0] led
);
  logic [63:0] src_s1;
  logic [63:0] src_s2;
  logic [63:0] enable;
  logic [63:0] arm;
  logic [63:0] level_sel;
  logic [63:0] pol_sel;
  logic [63:0] pending;
  logic [63:0] sw_req;
  logic [63:0] clr;
  logic [5:0] route [BIC_NEXT];
  logic ident_on;
  logic [31:0] blink_cnt;
  logic blink_ph;
  logic [BIC_NEV-1:0] ev_stat;
  logic [BIC_NEV-1:0] ev_en;
  logic [BIC_NEV-1:0] ev_hit;
  logic [BIC_NEV-1:0] ev_clr;
  logic [11:0] next_ext;
  logic [11:0] prev_ext;
  logic wr;
  logic rd;
  logic [31:0] next_rdata;
  logic next_err;
  logic [63:0] rt_word;
  logic ok_s1;
  logic ok_s2;

  assign wr = psel & penable & pwrite & pready;
  assign rd = psel & ~penable & ~pwrite;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      src_s1 <= 64'h0;
      src_s2 <= 64'h0;
    end else begin
      src_s1 <= irq_src;
      src_s2 <= src_s1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ok_s1 <= 1'b0;
      ok_s2 <= 1'b0;
    end else begin
      ok_s1 <= board_ok;
      ok_s2 <= ok_s1;
    end
  end

  // Software request and clear are single-cycle strobes from register writes.
  always_comb begin
    sw_req = 64'h0;
    clr = 64'h0;
    if (wr && paddr == BIC_ADDR_REQ1) begin
      sw_req[31:0] = pwdata;
    end else if (wr && paddr == BIC_ADDR_REQ2) begin
      sw_req[63:32] = pwdata;
    end else if (wr && paddr == BIC_ADDR_CLR1) begin
      clr[31:0] = pwdata;
    end else if (wr && paddr == BIC_ADDR_CLR2) begin
      clr[63:32] = pwdata;
    end
  end

  for (genvar i = 0; i < BIC_NSRC; i++) begin : g_src
    bic_source u_src (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .src_raw(src_s2[i]),
      .sw_req(sw_req[i]),
      .clr(clr[i]),
      .arm(arm[i]),
      .level_mode(level_sel[i]),
      .pol_high(pol_sel[i]),
      .pending(pending[i])
    );
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable <= 64'h0;
      arm <= 64'h0;
      level_sel <= 64'h0;
      pol_sel <= 64'h0;
      ident_on <= 1'b0;
      ev_en <= '0;
    end else if (wr) begin
      if (paddr == BIC_ADDR_EN1) begin
        enable[31:0] <= pwdata;
      end else if (paddr == BIC_ADDR_EN2) begin
        enable[63:32] <= pwdata;
      end else if (paddr == BIC_ADDR_ARM1) begin
        arm[31:0] <= pwdata;
      end else if (paddr == BIC_ADDR_ARM2) begin
        arm[63:32] <= pwdata;
      end else if (paddr == BIC_ADDR_LVL1) begin
        level_sel[31:0] <= pwdata;
      end else if (paddr == BIC_ADDR_LVL2) begin
        level_sel[63:32] <= pwdata;
      end else if (paddr == BIC_ADDR_POL1) begin
        pol_sel[31:0] <= pwdata;
      end else if (paddr == BIC_ADDR_POL2) begin
        pol_sel[63:32] <= pwdata;
      end else if (paddr == BIC_ADDR_IDENT) begin
        ident_on <= pwdata[BIC_IDENT_BIT];
      end else if (paddr == BIC_ADDR_IEN) begin
        ev_en <= pwdata[BIC_NEV-1:0];
      end
    end
  end

  // Routing: six-bit source numbers, four per register, top two bits reserved.
  for (genvar j = 0; j < BIC_NEXT; j++) begin : g_route
    localparam int unsigned RW = j / 4;
    localparam int unsigned RB = (j % 4) * 8;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        route[j] <= 6'h00;
      end else if (wr && paddr == (BIC_ADDR_RT1 + 12'(RW * 4))) begin
        route[j] <= pwdata[RB +: 6];
      end
    end
    assign next_ext[j] = pending[route[j]] & enable[route[j]];
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_out <= 64'h0;
      ext_irq <= 12'h000;
      prev_ext <= 12'h000;
    end else begin
      irq_out <= pending & enable;
      ext_irq <= next_ext;
      prev_ext <= next_ext;
    end
  end

  // Summary events: the first enabled pending rises while none was set, or any connector output rises.
  assign ev_hit[BIC_EV_PEND] = |(pending & enable) & ~|irq_out;
  assign ev_hit[BIC_EV_EXT] = |(next_ext & ~prev_ext);
  assign ev_clr = (wr && paddr == BIC_ADDR_ICLR) ? pwdata[BIC_NEV-1:0] : '0;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ev_stat <= '0;
    end else begin
      ev_stat <= ev_hit | (ev_stat & ~ev_clr);
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      host_irq <= 1'b0;
    end else begin
      host_irq <= |(ev_stat & ev_en);
    end
  end

  // Blink timer: toggles every half second, giving one red/green cycle per second.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blink_cnt <= 32'h0;
      blink_ph <= 1'b0;
    end else if (!ident_on) begin
      blink_cnt <= 32'h0;
      blink_ph <= 1'b0;
    end else if (blink_cnt == BLINK_CYC - 1) begin
      blink_cnt <= 32'h0;
      blink_ph <= ~blink_ph;
    end else begin
      blink_cnt <= blink_cnt + 32'h1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      led <= BIC_LED_OFF;
    end else if (ident_on) begin
      led <= blink_ph ? BIC_LED_GREEN : BIC_LED_RED;
    end else begin
      led <= ok_s2 ? BIC_LED_GREEN : BIC_LED_RED;
    end
  end

  assign rt_word = {2'h0, route[11], 2'h0, route[10], 2'h0, route[9], 2'h0, route[8],
                    2'h0, route[7], 2'h0, route[6], 2'h0, route[5], 2'h0, route[4]};

  // Read decode; write-only registers read as zero.
  always_comb begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    if (paddr == BIC_ADDR_STATUS) begin
      next_rdata[BIC_STAT_IRQ_BIT] = host_irq;
      next_rdata[BIC_STAT_IDENT_BIT] = ident_on;
    end else if (paddr == BIC_ADDR_FWREV) begin
      next_rdata = {BIC_FW_OPTIONS, BIC_FW_REV};
    end else if (paddr == BIC_ADDR_IDENT) begin
      next_rdata[BIC_IDENT_BIT] = ident_on;
    end else if (paddr == BIC_ADDR_EN1) begin
      next_rdata = enable[31:0];
    end else if (paddr == BIC_ADDR_EN2) begin
      next_rdata = enable[63:32];
    end else if (paddr == BIC_ADDR_REQ1) begin
      next_rdata = pending[31:0];
    end else if (paddr == BIC_ADDR_REQ2) begin
      next_rdata = pending[63:32];
    end else if (paddr == BIC_ADDR_CLR1 || paddr == BIC_ADDR_CLR2 || paddr == BIC_ADDR_ICLR) begin
      next_rdata = 32'h0;
    end else if (paddr == BIC_ADDR_ARM1) begin
      next_rdata = arm[31:0];
    end else if (paddr == BIC_ADDR_ARM2) begin
      next_rdata = arm[63:32];
    end else if (paddr == BIC_ADDR_LVL1) begin
      next_rdata = level_sel[31:0];
    end else if (paddr == BIC_ADDR_LVL2) begin
      next_rdata = level_sel[63:32];
    end else if (paddr == BIC_ADDR_POL1) begin
      next_rdata = pol_sel[31:0];
    end else if (paddr == BIC_ADDR_POL2) begin
      next_rdata = pol_sel[63:32];
    end else if (paddr == BIC_ADDR_RT1) begin
      next_rdata = {2'h0, route[3], 2'h0, route[2], 2'h0, route[1], 2'h0, route[0]};
    end else if (paddr == BIC_ADDR_RT2) begin
      next_rdata = rt_word[31:0];
    end else if (paddr == BIC_ADDR_RT3) begin
      next_rdata = rt_word[63:32];
    end else if (paddr == BIC_ADDR_ISTAT) begin
      next_rdata[BIC_NEV-1:0] = ev_stat;
    end else if (paddr == BIC_ADDR_IEN) begin
      next_rdata[BIC_NEV-1:0] = ev_en;
    end else begin
      next_err = 1'b1;
    end
  end

  // Answer is ready in the first access cycle; read data captured at setup.
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & next_err;
      if (rd) begin
        prdata <= next_rdata;
      end
    end
  end

  // Checks.
  ident_led_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ident_on && $past(ident_on) |-> led != BIC_LED_OFF && led == ($past(blink_ph) ? BIC_LED_GREEN : BIC_LED_RED))
    else $error("identify blink led mismatch");
  norm_led_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !ident_on |=> blink_ph == 1'b0)
    else $error("blink not stopped");
  gate_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 irq_out == ($past(pending) & $past(enable)))
    else $error("interrupt output not gated by enable");
  sw_req_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr && paddr == BIC_ADDR_REQ1 && pwdata[0] |=> pending[0])
    else $error("software request not pending");
  clr_pend_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    wr && paddr == BIC_ADDR_CLR1 && pwdata[0] && !level_sel[0] && !sw_req[0] && !arm[0] |=> !pending[0])
    else $error("clear did not remove request");
  unarmed_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !pending[1] && !arm[1] && !level_sel[1] && !sw_req[1] |=> !pending[1])
    else $error("unarmed edge captured");
  hold_pend_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    pending[2] && !clr[2] |=> pending[2])
    else $error("pending dropped without clear");
  route_out_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 ext_irq[0] == $past(pending[route[0]] & enable[route[0]]))
    else $error("routed output mismatch");
  fw_word_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd && paddr == BIC_ADDR_FWREV |=> prdata == {BIC_FW_OPTIONS, BIC_FW_REV})
    else $error("firmware word wrong");
  host_irq_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ##1 host_irq == |($past(ev_stat) & $past(ev_en)))
    else $error("host interrupt mismatch");
  pend_read_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rd && paddr == BIC_ADDR_REQ1 |=> prdata == $past(pending[31:0]))
    else $error("pending word read wrong");
  level_high_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    level_sel[4] && pol_sel[4] && src_s2[4] |=> pending[4])
    else $error("active high level not pending");
  level_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    level_sel[36] && !pol_sel[36] && !src_s2[36] |=> pending[36])
    else $error("active low level not pending");
  norm_status_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !ident_on |=> led == ($past(ok_s2) ? BIC_LED_GREEN : BIC_LED_RED))
    else $error("normal led status wrong");
  zero_wait_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    psel && !penable |=> pready)
    else $error("apb answer late");
  cov_level_c: cover property (@(posedge ref_clk) level_sel[4] && src_s2[4] ##1 pending[4]);
  cov_swreq_c: cover property (@(posedge ref_clk) wr && paddr == BIC_ADDR_REQ1 ##1 pending[0]);
  cov_ident_c: cover property (@(posedge ref_clk) ident_on ##1 blink_ph);
  cov_ext_c: cover property (@(posedge ref_clk) ext_irq != 12'h000);
  cov_err_c: cover property (@(posedge ref_clk) pslverr);
endmodule
`default_nettype wire

// ===== bic_src_model.sv
// Purpose: Drives the interrupt source pins as a field device would.
// Assumes: Levels change just after a rising edge of ref_clk.
// Notes: Pins sit low while reset is held.
`timescale 1ns/100ps
`default_nettype none
module bic_src_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Commanded levels and pins.
  input wire logic [63:0] want,
  output logic [63:0] irq_src
);
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_src <= 64'h0;
    end else begin
      irq_src <= want;
    end
  end
endmodule
`default_nettype wire

// ===== tb.sv
// Purpose: Self-checking bench for the board interrupt controller.
// Assumes: Zero wait APB slave; blink half period shortened to 4 cycles.
// Notes: Register rows first, then hand-written interrupt cases.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import bic_pkg::*;
  typedef struct packed {logic [11:0] a; logic [31:0] d; logic [31:0] e;} bic_row_t;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, host_irq, board_ok, err_q;
  logic [11:0] paddr, ext_irq;
  logic [31:0] pwdata, prdata, rd_q;
  logic [63:0] irq_src, irq_out, want;
  logic [1:0] led, seen;
  int failures, n_compared;
  bic_row_t rows [10] = '{
    '{BIC_ADDR_EN2, 32'hFFFF0000, 32'hFFFF0000},
    '{BIC_ADDR_ARM2, 32'h0000FFFF, 32'h0000FFFF},
    '{BIC_ADDR_POL2, 32'hA5A5A5A5, 32'hA5A5A5A5},
    '{BIC_ADDR_LVL2, 32'h0000F0F0, 32'h0000F0F0},
    '{BIC_ADDR_LVL2, 32'h00000000, 32'h00000000},
    '{BIC_ADDR_RT3, 32'h00213F05, 32'h00213F05},
    '{BIC_ADDR_IDENT, 32'h00000080, 32'h00000080},
    '{BIC_ADDR_IDENT, 32'h00000000, 32'h00000000},
    '{BIC_ADDR_FWREV, 32'hFFFFFFFF, {BIC_FW_OPTIONS, BIC_FW_REV}},
    '{BIC_ADDR_EN2, 32'h00000000, 32'h00000000}};

  bic_top #(.BLINK_CYC(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_src(irq_src), .irq_out(irq_out), .ext_irq(ext_irq), .host_irq(host_irq), .board_ok(board_ok),
    .led(led));
  bic_src_model src_m (.ref_clk(ref_clk), .sys_rst(sys_rst), .want(want), .irq_src(irq_src));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Holds the request until pready is seen high, then idles one cycle.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd_q = prdata;
    err_q = pslverr;
    if (n >= 20) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    final_report();
  end

  initial begin
    sys_rst = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0;
    want = 64'h0;
    board_ok = 1'b1;
    failures = 0;
    n_compared = 0;
    cyc(6);
    sys_rst <= 1'b0;
    cyc(1);
    for (int i = 0; i < 10; i++) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rows[i].e, rd_q);
    end
    apb(1'b0, 12'h0FC, 32'h0);
    chk(32'h1, {31'h0, err_q});
    apb(1'b1, BIC_ADDR_CLR2, 32'hFFFFFFFF);
    apb(1'b1, BIC_ADDR_EN1, 32'h0000001D);
    apb(1'b1, BIC_ADDR_REQ1, 32'h00000003);
    cyc(2);
    chk(32'h1, {30'h0, irq_out[1:0]});
    apb(1'b0, BIC_ADDR_REQ1, 32'h0);
    chk(32'h3, rd_q);
    apb(1'b1, BIC_ADDR_CLR1, 32'h00000003);
    apb(1'b0, BIC_ADDR_REQ1, 32'h0);
    chk(32'h0, rd_q);
    apb(1'b1, BIC_ADDR_POL1, 32'h00000014);
    apb(1'b1, BIC_ADDR_LVL1, 32'h00000010);
    apb(1'b1, BIC_ADDR_ARM1, 32'h00000000);
    want <= 64'h8;
    cyc(3);
    want <= 64'hC;
    cyc(3);
    want <= 64'h8;
    cyc(8);
    apb(1'b0, BIC_ADDR_REQ1, 32'h0);
    chk(32'h0, rd_q);
    apb(1'b1, BIC_ADDR_ARM1, 32'h0000000C);
    want <= 64'h4;
    cyc(3);
    want <= 64'h0;
    cyc(8);
    apb(1'b0, BIC_ADDR_REQ1, 32'h0);
    chk(32'hC, rd_q);
    want <= 64'h10;
    cyc(8);
    want <= 64'h0;
    cyc(8);
    apb(1'b0, BIC_ADDR_REQ1, 32'h0);
    chk(32'h1C, rd_q);
    apb(1'b1, BIC_ADDR_CLR1, 32'h0000001C);
    apb(1'b1, BIC_ADDR_RT1, 32'h00000200);
    apb(1'b1, BIC_ADDR_REQ1, 32'h00000001);
    cyc(3);
    chk(32'h1, {30'h0, ext_irq[1:0]});
    apb(1'b0, BIC_ADDR_ISTAT, 32'h0);
    chk(32'h3, rd_q);
    apb(1'b1, BIC_ADDR_IEN, 32'h00000001);
    cyc(2);
    chk(32'h1, {31'h0, host_irq});
    apb(1'b1, BIC_ADDR_IEN, 32'h00000000);
    cyc(2);
    chk(32'h0, {31'h0, host_irq});
    apb(1'b1, BIC_ADDR_CLR1, 32'h00000001);
    apb(1'b1, BIC_ADDR_ICLR, 32'h00000003);
    apb(1'b1, BIC_ADDR_IEN, 32'h00000003);
    cyc(2);
    chk(32'h0, {31'h0, host_irq});
    apb(1'b1, BIC_ADDR_REQ1, 32'h00000001);
    cyc(3);
    chk(32'h1, {31'h0, host_irq});
    apb(1'b1, BIC_ADDR_IDENT, 32'h00000080);
    seen = 2'b00;
    repeat (24) begin
      @(posedge ref_clk);
      if (led === BIC_LED_RED) seen[1] = 1'b1;
      if (led === BIC_LED_GREEN) seen[0] = 1'b1;
    end
    chk(32'h3, {30'h0, seen});
    apb(1'b1, BIC_ADDR_IDENT, 32'h00000000);
    cyc(2);
    chk({30'h0, BIC_LED_GREEN}, {30'h0, led});
    board_ok <= 1'b0;
    cyc(4);
    chk({30'h0, BIC_LED_RED}, {30'h0, led});
    sys_rst <= 1'b1;
    cyc(2);
    chk(32'h0, {17'h0, ext_irq, host_irq, led});
    sys_rst <= 1'b0;
    cyc(2);
    chk({30'h0, BIC_LED_RED}, {30'h0, led});
    final_report();
  end
endmodule
`default_nettype wire
